// ---- include/aosr_pkg.sv ----
// Constants and types of the one-shot/repeat converter control
package aosr_pkg;
    // Register word indices
    localparam logic [3:0] REG_CTRL0    = 4'h0;
    localparam logic [3:0] REG_CTRL1    = 4'h1;
    localparam logic [3:0] REG_CTRL2    = 4'h2;
    localparam logic [3:0] REG_CTRL3    = 4'h3;
    localparam logic [3:0] REG_IRQ_STAT = 4'h4;
    localparam logic [3:0] REG_IRQ_MASK = 4'h5;
    localparam logic [3:0] REG_RUN_STAT = 4'h6;
    localparam logic [3:0] REG_RES_BASE = 4'h8;
    // CTRL0 field positions
    localparam int CH_LSB      = 0;
    localparam int REPEAT_BIT  = 3;
    localparam int TRGSRC_BIT  = 4;
    localparam int START_BIT   = 5;
    localparam int DIVSEL_LSB  = 6;
    // CTRL1 / CTRL2 / CTRL3 field positions
    localparam int EXTSEL_LSB  = 0;
    localparam int RES10_BIT   = 2;
    localparam int GRPSEL_LSB  = 0;
    localparam int EXTSRC_BIT  = 2;
    localparam int DMA_BIT     = 0;
    // Values after reset
    localparam logic [7:0] CTRL0_RST = 8'h00;
    localparam logic [2:0] CTRL1_RST = 3'h0;
    localparam logic [2:0] CTRL2_RST = 3'h0;
    // Conversion-clock cycles per conversion
    localparam logic [6:0] CYC_8BIT  = 7'h31;
    localparam logic [6:0] CYC_10BIT = 7'h3b;
    // Input index of the two extended inputs
    localparam logic [5:0] IDX_EXT0 = 6'h20;
    localparam logic [5:0] IDX_EXT1 = 6'h21;
    // Control states
    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_CONV} aosr_state_t;
endpackage

// ---- hdl/aosr_fall_sync.sv ----
// Two-stage synchroniser with falling-edge pulse for the trigger pin
module aosr_fall_sync
(
    input  wire logic i_core_clk, // Core clock
    input  wire logic i_rst_b,    // Async reset, active low
    input  wire logic i_pin,      // Asynchronous pin level
    output logic      o_fall      // One-cycle pulse on high-to-low
);
    logic [2:0] sh_q; // Stage 0 feeds stage 1 only
    logic [2:0] sh_d; // Next shift value

    // Shift in; reset high so no false edge after release
    always_comb
    begin
        sh_d   = {sh_q[1:0], i_pin};
        o_fall = sh_q[2] & ~sh_q[1];
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            sh_q <= 3'h7;
        else
            sh_q <= sh_d;
    end
endmodule

// ---- hdl/aosr_conv_timer.sv ----
// Conversion timer: divided conversion clock and cycle count
module aosr_conv_timer #(
    parameter int CNT_W = 7, // Cycle counter width
    parameter int DIV_W = 3  // Prescaler width
)
(
    input  wire logic             i_core_clk, // Core clock
    input  wire logic             i_rst_b,    // Async reset, active low
    input  wire logic             i_run,      // Converting; low clears
    input  wire logic [DIV_W-1:0] i_div_m1,   // Divide ratio minus one
    input  wire logic [CNT_W-1:0] i_cycles,   // Cycles per conversion
    output logic                  o_done      // Pulse per finished conversion
);
    // Counter must hold the longer cycle count
    if (CNT_W < 6 || DIV_W < 1)
    begin : g_bad_param
        $error("aosr_conv_timer: CNT_W must be >= 6 and DIV_W >= 1");
    end

    logic [DIV_W-1:0] pre_q, pre_d; // Prescaler
    logic [CNT_W-1:0] cyc_q, cyc_d; // Conversion-clock cycles
    logic             done_q, done_d;

    // Counter wraps while running, so repeat mode restarts at once
    always_comb
    begin
        pre_d  = '0;
        cyc_d  = '0;
        done_d = 1'b0;
        if (i_run)
        begin
            if (pre_q == i_div_m1)
            begin
                if (cyc_q == i_cycles - CNT_W'(1))
                    done_d = 1'b1;
                else
                    cyc_d = cyc_q + CNT_W'(1);
            end
            else
            begin
                pre_d = pre_q + DIV_W'(1);
                cyc_d = cyc_q;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            pre_q  <= '0;
            cyc_q  <= '0;
            done_q <= 1'b0;
        end
        else
        begin
            pre_q  <= pre_d;
            cyc_q  <= cyc_d;
            done_q <= done_d;
        end
    end

    assign o_done = done_q;
endmodule

// ---- hdl/aosr_top.sv ----
// Converter control for one-shot and repeat modes with register port

// Functional notes
// - One-shot converts selected input once per software start, or once per trigger while armed
// - Input from channel, extended and group fields
// - Software trigger: writing start bit begins converting
// - Trigger pin falling edge starts once armed
// - Timer B2 request starts once armed
// - One-shot stops at completion; software trigger clears start
// - Writing start bit zero stops conversion
// - One-shot completion raises interrupt request
// - One of 32 group inputs or two extended
// - Non-DMA: result goes to channel-indexed register
// - DMA mode: every result into first register
// - Repeat uses same selection and start sources
// - Repeat stops only on start bit cleared
// - Repeat interrupts only when DMA mode set
// - 49 cycles at 8-bit, 59 at 10-bit
module aosr_top
    import aosr_pkg::*;
#(
    parameter int DATA_W = 16, // Register port data width
    parameter int RES_W  = 10  // Converter result width
)
(
    input  wire logic              i_core_clk,     // Core clock, 25 MHz
    input  wire logic              i_rst_b,        // Async reset, active low
    input  wire logic [3:0]        i_addr,         // Register word index
    input  wire logic [DATA_W-1:0] i_wdata,        // Write data
    input  wire logic              i_wr_stb,       // Write strobe
    input  wire logic              i_rd_stb,       // Read strobe
    output logic      [DATA_W-1:0] o_rdata,        // Read data, one cycle later
    input  wire logic              i_ext_trig_pin, // External trigger pin
    input  wire logic              i_tmr_b2_req,   // Timer B2 request pulse
    input  wire logic [RES_W-1:0]  i_adc_sample,   // Value from analog core
    output logic      [5:0]        o_sel_input,    // Selected analog input
    output logic                   o_converting,   // Analog core busy
    output logic                   o_irq,          // Interrupt, level
    output logic                   o_dma_req       // DMA request pulse
);
    // Refuse widths the register map cannot carry
    if (DATA_W < 8 || RES_W != 10)
    begin : g_bad_width
        $error("aosr_top: DATA_W must be >= 8 and RES_W must be 10");
    end

    // Control register state
    logic [7:0]       ctrl0_q, ctrl0_d; // Channel, mode, trigger, start
    logic [2:0]       ctrl1_q, ctrl1_d; // Extended select, resolution
    logic [2:0]       ctrl2_q, ctrl2_d; // Group select, external source
    logic             dma_q, dma_d;     // DMA operating mode
    logic             stat_q, stat_d;   // Sticky completion flag
    logic             mask_q, mask_d;   // Interrupt mask
    logic             irq_q, irq_d;     // Registered interrupt line
    logic             dreq_q, dreq_d;   // Registered DMA request
    aosr_state_t      state_q, state_d; // Control state
    logic [5:0]       sel_q, sel_d;     // Latched input index
    logic [DATA_W-1:0] rdata_q, rdata_d; // Read return
    logic [RES_W-1:0] res_q [8];        // Result registers
    logic [RES_W-1:0] res_d [8];        // Their next values

    // Decoded views of the control fields
    logic       repeat_md; // Repeat rather than one-shot
    logic       trg_hw;    // Hardware trigger selected
    logic       ext_src;   // Timer source instead of pin
    logic       res10;     // 10-bit resolution
    logic [2:0] chan;      // Channel field
    logic       wr_ctrl0;  // Write to control word 0
    logic       start_w;   // Written start value
    logic       set_start; // Start bit goes 0 to 1
    logic       stop_w;    // Start bit written to 0
    logic       trig_hit;  // Armed trigger event
    logic       done;      // Conversion finished
    logic       conv_end;  // Finished while converting
    logic       irq_evt;   // Completion interrupt event
    logic [2:0] res_idx;   // Result register to load
    logic       pin_fall;  // Synchronised pin falling edge
    logic [2:0] div_m1;    // Conversion clock divide minus one
    logic [6:0] cycles;    // Cycles for this resolution

    // Input index from group, channel and extended select
    function automatic logic [5:0] pick_input(input logic [2:0] ch,
                                              input logic [1:0] ext,
                                              input logic [1:0] grp);
        logic [5:0] idx;
        idx = {1'b0, grp, ch};
        case (ext)
            2'h1:    idx = IDX_EXT0;
            2'h2:    idx = IDX_EXT1;
            default: idx = {1'b0, grp, ch};
        endcase
        return idx;
    endfunction

    // Divide ratio of the conversion clock from the select field
    function automatic logic [2:0] div_code(input logic [1:0] sel);
        logic [2:0] d;
        case (sel)
            2'h0:    d = 3'h3; // Divide by 4
            2'h1:    d = 3'h2; // Divide by 3
            2'h2:    d = 3'h1; // Divide by 2
            default: d = 3'h0; // Undivided
        endcase
        return d;
    endfunction

    // Pin passes two flops before the edge detector sees it
    aosr_fall_sync u_pin_sync
    (
        .i_core_clk (i_core_clk),
        .i_rst_b    (i_rst_b),
        .i_pin      (i_ext_trig_pin),
        .o_fall     (pin_fall)
    );

    // Timer runs only while in the converting state
    aosr_conv_timer #(
        .CNT_W (7),
        .DIV_W (3)
    ) u_timer
    (
        .i_core_clk (i_core_clk),
        .i_rst_b    (i_rst_b),
        .i_run      (state_q == ST_CONV),
        .i_div_m1   (div_m1),
        .i_cycles   (cycles),
        .o_done     (done)
    );

    // Field decode shared by the processes below
    always_comb
    begin
        repeat_md = ctrl0_q[REPEAT_BIT];
        trg_hw    = ctrl0_q[TRGSRC_BIT];
        ext_src   = ctrl2_q[EXTSRC_BIT];
        res10     = ctrl1_q[RES10_BIT];
        chan      = ctrl0_q[CH_LSB +: 3];
        div_m1    = div_code(ctrl0_q[DIVSEL_LSB +: 2]);
        cycles    = res10 ? CYC_10BIT : CYC_8BIT;
        wr_ctrl0  = i_wr_stb && (i_addr == REG_CTRL0);
        start_w   = i_wdata[START_BIT];
        set_start = wr_ctrl0 && start_w && !ctrl0_q[START_BIT];
        stop_w    = wr_ctrl0 && !start_w;
        // Pin edge or timer pulse, seen only while armed
        trig_hit  = ext_src ? i_tmr_b2_req : pin_fall;
        conv_end  = done && (state_q == ST_CONV);
        // One-shot always; repeat only with DMA mode on
        irq_evt   = conv_end && (!repeat_md || dma_q);
        // DMA mode funnels every result into the first register
        res_idx   = dma_q ? 3'h0 : chan;
    end

    // Control state machine and start bit
    always_comb
    begin
        state_d = state_q;
        ctrl0_d = ctrl0_q;
        sel_d   = sel_q;
        if (wr_ctrl0)
            ctrl0_d = i_wdata[7:0];
        if (wr_ctrl0 && start_w && ctrl0_q[START_BIT])
            ctrl0_d[START_BIT] = 1'b1; // Rewrite of 1 keeps running
        case (state_q)
            ST_IDLE:
            begin
                if (set_start)
                begin
                    // Latch the selection for the whole run
                    sel_d = pick_input(i_wdata[CH_LSB +: 3],
                                       ctrl1_d[EXTSEL_LSB +: 2],
                                       ctrl2_d[GRPSEL_LSB +: 2]);
                    if (i_wdata[TRGSRC_BIT])
                        state_d = ST_ARMED;
                    else
                        state_d = ST_CONV;
                end
            end
            ST_ARMED:
            begin
                if (stop_w)
                    state_d = ST_IDLE;
                else if (trig_hit)
                    state_d = ST_CONV;
            end
            ST_CONV:
            begin
                if (stop_w)
                    state_d = ST_IDLE;
                else if (conv_end && !repeat_md)
                begin
                    // One-shot ends; hardware trigger re-arms
                    if (!trg_hw)
                    begin
                        state_d            = ST_IDLE;
                        ctrl0_d[START_BIT] = 1'b0;
                        if (wr_ctrl0 && start_w)
                        begin
                            // Software set beats the clear
                            ctrl0_d[START_BIT] = 1'b1;
                            state_d            = ST_CONV;
                        end
                    end
                    else
                        state_d = ST_ARMED;
                end
                // Repeat keeps running; timer wraps straight on
            end
            default:
                state_d = ST_IDLE;
        endcase
    end

    // Remaining configuration and interrupt registers
    always_comb
    begin
        ctrl1_d = ctrl1_q;
        ctrl2_d = ctrl2_q;
        dma_d   = dma_q;
        mask_d  = mask_q;
        stat_d  = stat_q;
        if (i_wr_stb)
        begin
            case (i_addr)
                REG_CTRL1:    ctrl1_d = i_wdata[2:0];
                REG_CTRL2:    ctrl2_d = i_wdata[2:0];
                REG_CTRL3:    dma_d   = i_wdata[DMA_BIT];
                REG_IRQ_MASK: mask_d  = i_wdata[0];
                REG_IRQ_STAT: stat_d  = stat_q & ~i_wdata[0]; // Write one clears
                default:      ;
            endcase
        end
        if (irq_evt)
            stat_d = 1'b1; // Event wins over a clear
        irq_d  = stat_d & mask_d;
        dreq_d = conv_end && dma_q;
    end

    // Result store: channel register, or the first one in DMA mode
    always_comb
    begin
        for (int i = 0; i < 8; i++)
            res_d[i] = res_q[i];
        if (conv_end)
        begin
            // 8-bit mode keeps the top bits, upper bits read zero
            if (res10)
                res_d[res_idx] = i_adc_sample;
            else
                res_d[res_idx] = {2'h0, i_adc_sample[RES_W-1:2]};
        end
    end

    // Read mux; data stand only in the cycle after the strobe
    always_comb
    begin
        rdata_d = '0;
        if (i_rd_stb)
        begin
            if (i_addr[3])
                rdata_d = DATA_W'(res_q[i_addr[2:0]]);
            else
            begin
                case (i_addr)
                    REG_CTRL0:    rdata_d = DATA_W'(ctrl0_q);
                    REG_CTRL1:    rdata_d = DATA_W'(ctrl1_q);
                    REG_CTRL2:    rdata_d = DATA_W'(ctrl2_q);
                    REG_CTRL3:    rdata_d = DATA_W'(dma_q);
                    REG_IRQ_STAT: rdata_d = DATA_W'(stat_q);
                    REG_IRQ_MASK: rdata_d = DATA_W'(mask_q);
                    REG_RUN_STAT: rdata_d = DATA_W'({state_q == ST_CONV,
                                                     state_q == ST_ARMED});
                    default:      rdata_d = '0; // Unmapped reads zero
                endcase
            end
        end
    end

    // Register everything
    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state_q <= ST_IDLE;
            ctrl0_q <= CTRL0_RST;
            ctrl1_q <= CTRL1_RST;
            ctrl2_q <= CTRL2_RST;
            dma_q   <= 1'b0;
            stat_q  <= 1'b0;
            mask_q  <= 1'b0;
            irq_q   <= 1'b0;
            dreq_q  <= 1'b0;
            sel_q   <= '0;
            rdata_q <= '0;
            for (int i = 0; i < 8; i++)
                res_q[i] <= '0;
        end
        else
        begin
            state_q <= state_d;
            ctrl0_q <= ctrl0_d;
            ctrl1_q <= ctrl1_d;
            ctrl2_q <= ctrl2_d;
            dma_q   <= dma_d;
            stat_q  <= stat_d;
            mask_q  <= mask_d;
            irq_q   <= irq_d;
            dreq_q  <= dreq_d;
            sel_q   <= sel_d;
            rdata_q <= rdata_d;
            for (int i = 0; i < 8; i++)
                res_q[i] <= res_d[i];
        end
    end

    // Converting flag registered from the next state
    logic conv_q;
    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            conv_q <= 1'b0;
        else
            conv_q <= (state_d == ST_CONV);
    end

    assign o_rdata      = rdata_q;
    assign o_sel_input  = sel_q;
    assign o_converting = conv_q;
    assign o_irq        = irq_q;
    assign o_dma_req    = dreq_q;
endmodule

// ---- testbench/aosr_checker_assertions.sv ----
// Concurrent checks on the converter control ports
module aosr_checker
    import aosr_pkg::*;
#(
    parameter int DATA_W = 16 // Register data width
)
(
    input wire logic              i_core_clk,   // Core clock
    input wire logic              i_rst_b,      // Reset, active low
    input wire logic [3:0]        i_addr,       // Register index
    input wire logic [DATA_W-1:0] i_wdata,      // Write data
    input wire logic              i_wr_stb,     // Write strobe
    input wire logic              i_rd_stb,     // Read strobe
    input wire logic [DATA_W-1:0] o_rdata,      // Read data
    input wire logic [5:0]        o_sel_input,  // Selected input
    input wire logic              o_converting, // Core busy
    input wire logic              o_irq,        // Interrupt level
    input wire logic              o_dma_req     // DMA pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    logic [7:0] cnt_q;  // Cycles spent converting, saturating
    logic       stop_q; // Stop written during this conversion
    logic       ctl_wr; // Write to the first control word
    assign ctl_wr = i_wr_stb && i_addr == REG_CTRL0;
    // Early stops are marked so the length check skips them
    always_ff @(posedge i_core_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            cnt_q  <= 8'h00;
            stop_q <= 1'b0;
        end
        else
        begin
            cnt_q  <= o_converting ? cnt_q + 8'(cnt_q != 8'hff) : 8'h00;
            stop_q <= o_converting && (stop_q || (ctl_wr && !i_wdata[START_BIT]));
        end
    end
    a_rdata_idle: assert property (!$past(i_rd_stb) |-> o_rdata == '0)
        else $error("read data not idle");
    a_sw_start: assert property (ctl_wr && i_wdata[START_BIT] && !i_wdata[TRGSRC_BIT]
        && !o_converting |=> o_converting)
        else $error("software start ignored");
    a_stop_write: assert property (ctl_wr && !i_wdata[START_BIT] |=> !o_converting)
        else $error("stop write ignored");
    a_irq_masked: assert property (i_wr_stb && i_addr == REG_IRQ_MASK && !i_wdata[0]
        |=> ##1 !o_irq)
        else $error("masked interrupt seen");
    a_dma_pulse: assert property (o_dma_req |=> !o_dma_req)
        else $error("DMA request too long");
    a_dma_cause: assert property (o_dma_req |-> $past(o_converting))
        else $error("DMA request without conversion");
    a_sel_stable: assert property ($past(o_converting) && o_converting
        |-> $stable(o_sel_input))
        else $error("input changed while converting");
    a_min_conv_len: assert property ($fell(o_converting) && !stop_q
        |-> cnt_q >= 8'h31)
        else $error("conversion too short");
    c_irq: cover property ($rose(o_irq));
    c_dma: cover property (o_dma_req);
    c_abort: cover property ($fell(o_converting) && stop_q);
endmodule

bind aosr_top aosr_checker #(.DATA_W(DATA_W)) u_chk (.i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr_stb(i_wr_stb),
    .i_rd_stb(i_rd_stb), .o_rdata(o_rdata), .o_sel_input(o_sel_input),
    .o_converting(o_converting), .o_irq(o_irq), .o_dma_req(o_dma_req));

// ---- testbench/aosr_far_model.sv ----
// Far-side model: trigger pin, timer pulse and analog core
module aosr_far_model
(
    input  wire logic       i_core_clk, // Core clock
    input  wire logic       i_pin_go,   // Bench asks for a pin edge
    input  wire logic       i_tmr_go,   // Bench asks for a timer pulse
    input  wire logic [9:0] i_level,    // Code to present
    input  wire logic       i_busy,     // Design converting
    output logic            o_pin,      // Trigger pin, idle high
    output logic            o_tmr_req,  // Timer request pulse
    output logic [9:0]      o_sample    // Core result lines
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] low_q = 3'h0;  // Cycles left with pin low
    logic [9:0] smp_q = 10'h0; // Core output register
    assign o_pin = (low_q == 3'h0);
    // Pin held low four cycles so the synchroniser sees it
    always_ff @(posedge i_core_clk)
    begin
        low_q     <= i_pin_go ? 3'h4 : low_q - 3'(low_q != 3'h0);
        o_tmr_req <= i_tmr_go;
        // Outside a conversion the lines churn, never hold
        smp_q     <= i_busy ? i_level : ~smp_q;
    end
    assign o_sample = smp_q;
endmodule

// ---- testbench/tb_adc_oneshot_repeat_control.sv ----
// Self-checking bench for the converter control
module tb_adc_oneshot_repeat_control
    import aosr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst_b = 0, wr = 0, rd = 0, pin_go = 0, tmr_go = 0;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000, rdata;
    logic [9:0]  level = 10'h000, lvl, smp;
    logic        pin, tmr, conv, irq, dma;
    logic [5:0]  sel;
    logic [15:0] exp_q[$]; // Expected read data
    int          n_fail = 0, cmp_count = 0, n_dma, n_wait;
    aosr_top dut (.i_core_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata),
        .i_wr_stb(wr), .i_rd_stb(rd), .o_rdata(rdata), .i_ext_trig_pin(pin),
        .i_tmr_b2_req(tmr), .i_adc_sample(smp), .o_sel_input(sel),
        .o_converting(conv), .o_irq(irq), .o_dma_req(dma));
    aosr_far_model far (.i_core_clk(clk), .i_pin_go(pin_go), .i_tmr_go(tmr_go),
        .i_level(level), .i_busy(conv), .o_pin(pin), .o_tmr_req(tmr), .o_sample(smp));
    initial forever #20 clk = ~clk;
    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        cmp_count++;
        if (seen !== want)
        begin
            n_fail++;
            $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [15:0] want);
        exp_q.push_back(want);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask
    // Bounded wait on the busy flag, then compare it
    task automatic wait_conv(input logic want);
        int k;
        k = 0;
        while (conv !== want && k < 400)
        begin
            @(posedge clk);
            k++;
        end
        n_wait = k;
        chk(16'(conv), 16'(want));
    endtask
    task automatic complete_run;
        $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Read data stands one cycle after the strobe
    initial
    begin
        logic rd_prev;
        rd_prev = 0;
        forever
        begin
            @(negedge clk);
            if (rd_prev)
                chk(rdata, exp_q.pop_front());
            rd_prev = rd;
        end
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        complete_run();
    end
    initial
    begin
        logic [2:0] ch;
        logic [1:0] grp, ext, dv;
        logic [5:0] want;
        void'($urandom(35525));
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        // Reset values, unmapped word reads zero
        for (int a = 0; a < 8; a++)
            rd_reg(4'(a), 16'h0000);
        $display("test reset done");
        // Software one-shot over inputs and resolutions
        wr_reg(REG_IRQ_MASK, 16'h0001);
        for (int i = 0; i < 6; i++)
        begin
            ch = 3'($urandom % 8);
            grp = 2'($urandom % 4);
            ext = 2'(i % 3);
            lvl = 10'($urandom % 1024);
            dv = 2'($urandom % 4);
            level <= lvl;
            want = ext == 2'd1 ? IDX_EXT0 : ext == 2'd2 ? IDX_EXT1 : {1'b0, grp, ch};
            wr_reg(REG_CTRL2, 16'(grp));
            wr_reg(REG_CTRL1, 16'({i[0], ext}));
            wr_reg(REG_CTRL0, 16'h0020 | 16'({dv, 6'h00}) | 16'(ch));
            chk(16'(conv), 16'h0001);
            chk(16'(sel), 16'(want));
            wait_conv(1'b0);
            // Length: cycles times divide ratio, plus the registered done
            chk(16'(n_wait), 16'(i[0] ? CYC_10BIT : CYC_8BIT) * 16'(4 - dv) + 16'h0001);
            chk(16'(irq), 16'h0001);
            rd_reg(REG_RES_BASE + 4'(ch), i[0] ? 16'(lvl) : 16'(lvl[9:2]));
            rd_reg(REG_CTRL0, 16'({dv, 6'h00}) | 16'(ch));
            wr_reg(REG_IRQ_STAT, 16'h0001);
            chk(16'(irq), 16'h0000);
        end
        $display("test one-shot done");
        // Pin and timer triggers, then a stop mid-run
        wr_reg(REG_CTRL1, 16'h0000);
        for (int s = 0; s < 2; s++)
        begin
            wr_reg(REG_CTRL2, 16'(s << EXTSRC_BIT));
            wr_reg(REG_CTRL0, 16'h00f0);
            for (int n = 0; n < 2; n++)
            begin
                repeat (10) @(posedge clk);
                chk(16'(conv), 16'h0000);
                if (s == 0)
                    pin_go <= 1'b1;
                else
                    tmr_go <= 1'b1;
                @(posedge clk);
                pin_go <= 1'b0;
                tmr_go <= 1'b0;
                wait_conv(1'b1);
                if (n == 0)
                begin
                    wait_conv(1'b0);
                    rd_reg(REG_RES_BASE, 16'(lvl[9:2]));
                    rd_reg(REG_RUN_STAT, 16'h0001);
                    wr_reg(REG_IRQ_MASK, 16'h0000);
                    chk(16'(irq), 16'h0000);
                    rd_reg(REG_IRQ_STAT, 16'h0001);
                    wr_reg(REG_IRQ_STAT, 16'h0001);
                    wr_reg(REG_IRQ_MASK, 16'h0001);
                end
            end
            repeat (10) @(posedge clk);
            wr_reg(REG_CTRL0, 16'h00d0);
            chk(16'(conv), 16'h0000);
            repeat (70) @(posedge clk);
            rd_reg(REG_IRQ_STAT, 16'h0000);
            rd_reg(REG_RUN_STAT, 16'h0000);
        end
        $display("test triggers done");
        // Repeat mode without and with DMA
        wr_reg(REG_CTRL2, 16'h0000);
        for (int d = 0; d < 2; d++)
        begin
            wr_reg(REG_CTRL3, 16'(d));
            wr_reg(REG_CTRL0, 16'h00ed);
            n_dma = 0;
            repeat (200)
            begin
                @(posedge clk);
                if (dma === 1'b1)
                    n_dma++;
            end
            chk(16'(conv), 16'h0001);
            chk(16'(n_dma >= 3), 16'(d));
            chk(16'(irq), 16'(d));
            wr_reg(REG_CTRL0, 16'h00cd);
            chk(16'(conv), 16'h0000);
            wr_reg(REG_CTRL3, 16'h0000);
            // Result read only once DMA is off: channel 5 register, or the first one after DMA
            rd_reg(REG_RES_BASE + 4'(5 - 5 * d), 16'(lvl[9:2]));
            wr_reg(REG_IRQ_STAT, 16'h0001);
        end
        $display("test repeat done");
        complete_run();
    end
endmodule
